/* common/pulse_counter_defs.svh */
// Purpose: Constants for the sixteen-channel pulse counter
// Assumes: 100 MHz clock
// Notes:   Times in their own unit, cycle counts derived
`ifndef PULSE_COUNTER_DEFS_SVH
`define PULSE_COUNTER_DEFS_SVH
`define PC_CLK_HZ          100000000
`define PC_TICK_NS         100000
`define PC_TICK_CYCLES     (`PC_TICK_NS / 10)
`define PC_MIN_WIDTH_US    500
`define PC_MIN_WIDTH_TICKS ((`PC_MIN_WIDTH_US * 1000 + `PC_TICK_NS - 1) / `PC_TICK_NS)
`define PC_MIN_PERIOD_US   1000
`define PC_MIN_PERIOD_TICKS ((`PC_MIN_PERIOD_US * 1000 + `PC_TICK_NS - 1) / `PC_TICK_NS)
`define PC_DEBOUNCE_TICKS  50
`define PC_LINK_IDLE_TICKS 20000
`define PC_BLINK_TICKS     500
`define PC_CHANNELS        16
`define PC_COUNT_WIDTH     16
`endif

/* common/pulse_counter_pkg.sv */
// Purpose: Types for the sixteen-channel pulse counter
// Assumes: Constants come from pulse_counter_defs.svh
// Notes:   Count type and carrier structs only
`default_nettype none
package pulse_counter_pkg;
   typedef logic [15:0] count_t;
   typedef struct packed {
      logic        valid; // Read request strobe
      logic [3:0]  chan;  // Channel index
   } read_req_s;
   typedef struct packed {
      logic        valid; // Answer strobe
      logic        level; // Filtered input level
      count_t      count; // Counter value
   } read_rsp_s;
   typedef struct packed {
      logic        save;  // Store all counts
      logic        load;  // Counts were restored
   } nv_ctrl_s;
endpackage
`default_nettype wire

/* logic/pulse_channel.sv */
// Purpose: One input channel: qualify rising edges and count them
// Assumes: Input already synchronised; tick is one-cycle 0.1 ms enable
// Notes:   Widths and periods measured in ticks
`timescale 1ns/1ns
`default_nettype none
`include "pulse_counter_defs.svh"
module pulse_channel
   import pulse_counter_pkg::*;
#(
   parameter int MIN_HIGH   = `PC_MIN_WIDTH_TICKS,
   parameter int MIN_PERIOD = `PC_MIN_PERIOD_TICKS,
   parameter int DEB_TICKS  = `PC_DEBOUNCE_TICKS
) (
   input  wire logic   clk,       // System clock
   input  wire logic   sys_rst,   // Synchronous reset
   input  wire logic   tick,      // Timebase enable
   input  wire logic   syncIn,    // Synchronised input
   input  wire logic   debounceOn,// Debounce enable
   input  wire logic   clear,     // Clear count
   input  wire logic   load,      // Load stored count
   input  wire count_t loadValue, // Stored count
   output logic        level,     // Filtered level
   output count_t      count,     // Edge count
   output logic        bump       // One-cycle count pulse
);
   logic [7:0]  debCnt;
   logic        debLevel;
   logic [15:0] highTicks;
   logic [15:0] sinceEdge;
   logic        qualified;
   logic        prevIn;
   logic [15:0] tickHigh;

   // Debounce: level must hold for DEB_TICKS before it is taken
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         debCnt   <= 8'h00;
         debLevel <= 1'b0;
      end else if (syncIn == debLevel) begin
         debCnt <= 8'h00;
      end else if (tick) begin
         if (debCnt >= 8'(DEB_TICKS - 1)) begin
            debLevel <= syncIn;
            debCnt   <= 8'h00;
         end else begin
            debCnt <= debCnt + 8'h01;
         end
      end
   end

   assign level = debounceOn ? debLevel : syncIn;

   // Width and period timing on the timebase
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prevIn    <= 1'b0;
         highTicks <= 16'h0000;
         sinceEdge <= 16'hFFFF;
         qualified <= 1'b0;
      end else begin
         prevIn <= level;
         if (level && !prevIn) begin
            highTicks <= 16'h0000;
            // Edge too soon after the last one marks a too-fast train
            qualified <= (sinceEdge >= 16'(MIN_PERIOD - 1));
            sinceEdge <= 16'h0000;
         end else begin
            if (tick && level && highTicks != 16'hFFFF) highTicks <= highTicks + 16'h0001;
            if (tick && sinceEdge != 16'hFFFF) sinceEdge <= sinceEdge + 16'h0001;
            if (!level) qualified <= 1'b0;
         end
      end
   end

   // Count once the pulse has been high long enough, once per pulse
   assign bump = qualified && level && tick && (highTicks == 16'(MIN_HIGH - 1));

   always_ff @(posedge clk) begin
      if (sys_rst || clear) count <= 16'h0000;
      else if (load) count <= loadValue;
      else if (bump) count <= count + 16'h0001; // Wraps to zero
   end

   // Checking aid: ticks seen while high, kept apart from highTicks so the width check is independent
   always_ff @(posedge clk) begin
      if (sys_rst || !level) tickHigh <= 16'h0000;
      else if (tick && tickHigh != 16'hFFFF) tickHigh <= tickHigh + 16'h0001;
   end

   // Count never moves while the level is low, unless cleared or loaded
   property p_no_count_low;
      @(posedge clk) disable iff (sys_rst)
         !level && !clear && !load |=> $stable(count);
   endproperty
   a_no_count_low: assert property (p_no_count_low) else $error("count moved while input low");
   property p_wrap;
      @(posedge clk) disable iff (sys_rst)
         bump && !clear && !load && count == 16'hFFFF |=> count == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");
   property p_inc;
      @(posedge clk) disable iff (sys_rst)
         bump && !clear && !load |=> count == $past(count) + 16'h0001;
   endproperty
   a_inc: assert property (p_inc) else $error("counter did not increment");
   property p_short;
      @(posedge clk) disable iff (sys_rst)
         bump |-> tickHigh >= 16'(MIN_HIGH - 1);
   endproperty
   a_short: assert property (p_short) else $error("count before minimum width");
endmodule
`default_nettype wire

/* logic/multi_channel_pulse_counter.sv */
// Contract
// - Each of sixteen channels has its own 16-bit counter.
// - Pulse trains faster than 1 kHz are not counted.
// - Pulses narrower than 0.5 ms cause no increment.
// - Count qualified rising edges only, never falling edges.
// - Counter values are kept in non-volatile storage across power loss.
// - Counter wraps past maximum to zero and keeps counting.
// - Per-channel debounce filter, enabled separately by configuration.
// - Serial activity indicator toggles while data is exchanged.
// - Fault indicator lights when serial exchange is broken.
// - Sixteen indicators, each lit while its input is one.
// - Device only answers requests; one external master starts each.
// - With write protect fitted, counters clear after power loss.
//
// Purpose: Sixteen-channel input sampler and rising-edge pulse counter
// Assumes: Protocol engine outside gives read requests and byte strobes
// Notes:   Non-volatile store is outside; this block requests saves
`timescale 1ns/1ns
`default_nettype none
`include "pulse_counter_defs.svh"
module multi_channel_pulse_counter
   import pulse_counter_pkg::*;
#(
   parameter int CHANNELS   = `PC_CHANNELS,
   parameter int TICK_CYC   = `PC_TICK_CYCLES,
   parameter int LINK_IDLE  = `PC_LINK_IDLE_TICKS,
   parameter int BLINK      = `PC_BLINK_TICKS
) (
   input  wire logic                     clk,          // 100 MHz clock
   input  wire logic                     sys_rst,      // Synchronous reset
   input  wire logic [CHANNELS-1:0]      digitalInputChannel, // Raw input pins
   input  wire logic [CHANNELS-1:0]      debounceEnable,      // Per-channel filter on
   input  wire logic                     nvWriteProtectJumper,// Jumper fitted
   input  wire logic                     nvRestoreValid,      // Stored counts ready
   input  wire count_t [CHANNELS-1:0]    nvRestoreCount,      // Stored counts
   input  wire logic                     serialByte,   // Byte exchanged pulse
   input  wire logic                     serialError,  // Exchange broken pulse
   input  wire read_req_s                readReq,      // Master read request
   output read_rsp_s                     readRsp,      // Read answer
   output nv_ctrl_s                      nvCtrl,       // Store control
   output count_t [CHANNELS-1:0]         nvSaveCount,  // Counts to store
   output logic [CHANNELS-1:0]           inputLed,     // Per-input indicators
   output logic                          serialActivityIndicator, // Activity LED
   output logic                          faultLed      // Fault LED
);
   typedef enum logic [1:0] {
      ST_BOOT = 2'b00,
      ST_RUN  = 2'b01
   } boot_e;

   boot_e                 bootState;
   logic [CHANNELS-1:0]   syncA;
   logic [CHANNELS-1:0]   syncB;
   logic [15:0]           tickCnt;
   logic                  tick;
   logic [CHANNELS-1:0]   level;
   logic [CHANNELS-1:0]   bump;
   count_t [CHANNELS-1:0] count;
   logic                  clearAll;
   logic                  loadAll;
   logic                  saveDue;
   logic [15:0]           idleTicks;
   logic [15:0]           blinkTicks;

   // ==========================================================
   // Input synchroniser and timebase
   // Pins are asynchronous; two flops before any logic
   always_ff @(posedge clk) begin
      syncA <= digitalInputChannel;
      syncB <= syncA;
   end

   // Free-running 0.1 ms enable, never reset by activity
   always_ff @(posedge clk) begin
      if (sys_rst || tickCnt == 16'(TICK_CYC - 1)) tickCnt <= 16'h0000;
      else tickCnt <= tickCnt + 16'h0001;
   end
   assign tick = (tickCnt == 16'(TICK_CYC - 1));

   // ==========================================================
   // Power-up: restore stored counts or clear them
   always_ff @(posedge clk) begin
      if (sys_rst) bootState <= ST_BOOT;
      else if (bootState == ST_BOOT && (nvWriteProtectJumper || nvRestoreValid)) bootState <= ST_RUN;
   end
   // Protected store cannot be trusted across power loss, so clear
   assign clearAll = bootState == ST_BOOT && nvWriteProtectJumper;
   assign loadAll  = bootState == ST_BOOT && !nvWriteProtectJumper && nvRestoreValid;

   // ==========================================================
   // Channels
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : gen_chan
         pulse_channel u_chan (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .tick       (tick),
            .syncIn     (syncB[g]),
            .debounceOn (debounceEnable[g]),
            .clear      (clearAll),
            .load       (loadAll),
            .loadValue  (nvRestoreCount[g]),
            .level      (level[g]),
            .count      (count[g]),
            .bump       (bump[g])
         );
      end
   endgenerate

   // Indicators follow the synchronised inputs
   always_ff @(posedge clk) begin
      if (sys_rst) inputLed <= '0;
      else inputLed <= syncB;
   end

   // Save two cycles after the bump, so the stored copy already holds the new count
   always_ff @(posedge clk) begin
      if (sys_rst) saveDue <= 1'b0;
      else saveDue <= (|bump) && !nvWriteProtectJumper && bootState == ST_RUN;
   end

   // Save on every count increment after boot; write protect blocks it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nvCtrl      <= '0;
         nvSaveCount <= '0;
      end else begin
         nvCtrl.save <= saveDue;
         nvCtrl.load <= loadAll;
         nvSaveCount <= count;
      end
   end

   // ==========================================================
   // Read answers: only ever in reply to a request
   always_ff @(posedge clk) begin
      if (sys_rst) readRsp <= '0;
      else begin
         readRsp.valid <= readReq.valid;
         if (readReq.valid) begin
            readRsp.level <= level[readReq.chan];
            readRsp.count <= count[readReq.chan];
         end
      end
   end

   // ==========================================================
   // Serial indicators
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serialActivityIndicator <= 1'b0;
         blinkTicks              <= 16'h0000;
      end else if (serialByte && blinkTicks == 16'h0000) begin
         serialActivityIndicator <= ~serialActivityIndicator;
         blinkTicks              <= 16'(BLINK);
      end else if (tick && blinkTicks != 16'h0000) begin
         blinkTicks <= blinkTicks - 16'h0001; // Keeps blink visible
      end
   end

   // Fault on broken frame, or LINK_IDLE ticks of silence at any time; cleared by a good byte
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         faultLed  <= 1'b0;
         idleTicks <= 16'h0000;
      end else if (serialError) begin
         faultLed  <= 1'b1;
         idleTicks <= 16'h0000;
      end else if (serialByte) begin
         faultLed  <= 1'b0;
         idleTicks <= 16'h0000;
      end else if (tick) begin
         if (idleTicks == 16'(LINK_IDLE - 1)) faultLed <= 1'b1;
         else idleTicks <= idleTicks + 16'h0001;
      end
   end

   // ==========================================================
   // Checks
   property p_tick;
      @(posedge clk) disable iff (sys_rst)
         tick |=> !tick;
   endproperty
   a_tick: assert property (p_tick) else $error("timebase enable longer than one cycle");
   property p_led;
      @(posedge clk) disable iff (sys_rst)
         1'b1 |=> inputLed == $past(syncB);
   endproperty
   a_led: assert property (p_led) else $error("indicator does not follow input");
   property p_rsp;
      @(posedge clk) disable iff (sys_rst)
         readRsp.valid |-> $past(readReq.valid);
   endproperty
   a_rsp: assert property (p_rsp) else $error("answer without request");
   property p_fault;
      @(posedge clk) disable iff (sys_rst)
         serialError |=> faultLed;
   endproperty
   a_fault: assert property (p_fault) else $error("fault not lit on broken exchange");
   property p_clear;
      @(posedge clk) disable iff (sys_rst)
         clearAll |=> count[0] == 16'h0000;
   endproperty
   a_clear: assert property (p_clear) else $error("counter not cleared under write protect");
   // Save strobe trails the bump by two edges, when the stored copy is current
   property p_save;
      @(posedge clk) disable iff (sys_rst)
         bump[0] && bootState == ST_RUN && !nvWriteProtectJumper |-> ##2 nvCtrl.save;
   endproperty
   a_save: assert property (p_save) else $error("count change not stored");
   property p_blink;
      @(posedge clk) disable iff (sys_rst)
         serialByte && blinkTicks == 16'h0000 |=> serialActivityIndicator != $past(serialActivityIndicator);
   endproperty
   a_blink: assert property (p_blink) else $error("activity indicator did not toggle");
endmodule
`default_nettype wire

/* tb/modbus_master_model.sv */
// Purpose: Bus master model that starts every exchange
// Assumes: Drives on falling clock edges
// Notes:   Breaks the link only when told to
`timescale 1ns/1ns
`default_nettype none
module modbus_master_model (
   input  wire logic                       clk,        // System clock
   input  wire pulse_counter_pkg::read_rsp_s readRsp,  // Device answer
   output pulse_counter_pkg::read_req_s    readReq,    // Read request
   output logic                            serialByte, // Byte strobe
   output logic                            serialError // Broken exchange
);
   import pulse_counter_pkg::*;
   // ==========================================
   // Idle line at time zero
   initial begin
      readReq = '0;
      serialByte = 1'b0;
      serialError = 1'b0;
   end
   // One byte, then a gap past the blink hold-off
   task automatic sendByte();
      @(negedge clk);
      serialByte = 1'b1;
      @(negedge clk);
      serialByte = 1'b0;
      repeat (30) @(negedge clk);
   endtask
   // Request frame, read strobe, answer taken next cycle
   task automatic readChan(input logic [3:0] ch, output read_rsp_s rsp);
      sendByte();
      @(negedge clk);
      readReq = '{valid: 1'b1, chan: ch};
      @(negedge clk);
      readReq = '0;
      rsp = readRsp;
      sendByte();
   endtask
   // Exchange aborted in mid-frame
   task automatic breakLink();
      @(negedge clk);
      serialError = 1'b1;
      @(negedge clk);
      serialError = 1'b0;
   endtask
endmodule
`default_nettype wire

/* tb/multi_channel_pulse_counter_tb_top.sv */
// Purpose: Self-checking bench for the pulse counter
// Assumes: Tick shortened to 10 cycles, so 0.5 ms is 50 cycles
// Notes:   Pulse times keep a tick of margin for timebase phase
`timescale 1ns/1ns
`default_nettype none
module multi_channel_pulse_counter_tb_top;
   import pulse_counter_pkg::*;
   logic          clk, sysRst, jumper, restoreValid;
   logic [15:0]   din, debEn, inputLed;
   count_t [15:0] restoreCount, saveCount;
   read_req_s     readReq;
   read_rsp_s     readRsp, rsp;
   nv_ctrl_s      nvCtrl;
   logic          serialByte, serialError, actLed, faultLed, prevAct;
   count_t        expCnt [16];
   int            failures, n_compared, nSaves, nLoads;
   // ==========================================
   multi_channel_pulse_counter #(.TICK_CYC(10), .LINK_IDLE(20), .BLINK(2)) dut (
      .clk(clk), .sys_rst(sysRst), .digitalInputChannel(din), .debounceEnable(debEn),
      .nvWriteProtectJumper(jumper), .nvRestoreValid(restoreValid),
      .nvRestoreCount(restoreCount), .serialByte(serialByte), .serialError(serialError),
      .readReq(readReq), .readRsp(readRsp), .nvCtrl(nvCtrl), .nvSaveCount(saveCount),
      .inputLed(inputLed), .serialActivityIndicator(actLed), .faultLed(faultLed));
   modbus_master_model master (.clk(clk), .readRsp(readRsp), .readReq(readReq),
      .serialByte(serialByte), .serialError(serialError));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Save strobes counted for the wrap and write-protect cases
   always @(posedge clk) if (nvCtrl.save === 1'b1) nSaves++;
   // Restore strobes, one expected after the first reset
   always @(posedge clk) if (nvCtrl.load === 1'b1) nLoads++;
   // ==========================================
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic readChk(input int ch);
      master.readChan(ch[3:0], rsp);
      chk("rsp valid", 16'h0001, {15'h0000, rsp.valid});
      chk($sformatf("count %0d", ch), expCnt[ch], rsp.count);
   endtask
   task automatic doReset(input logic jump);
      @(negedge clk);
      sysRst = 1'b1;
      jumper = jump;
      repeat (8) @(negedge clk);
      sysRst = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   // High then low; counts are bumped by the caller
   task automatic pulse(input logic [15:0] mask, input int hi, input int lo);
      @(negedge clk);
      din = din | mask;
      repeat (hi) @(negedge clk);
      din = din & ~mask;
      repeat (lo) @(negedge clk);
   endtask
   // ==========================================
   task automatic t_channels();
      pulse(16'hA5C3, 80, 80);
      for (int i = 0; i < 16; i++) if (i[3:0] inside {0,1,6,7,8,10,13,15}) expCnt[i]++;
      for (int i = 0; i < 16; i++) readChk(i);
      chk("loads", 16'h0001, nLoads[15:0]);
      $display("done channels");
   endtask
   task automatic t_wrap();
      int saves0;
      saves0 = nSaves;
      pulse(16'h0008, 80, 80);
      expCnt[3] = 16'hFFFF;
      readChk(3);
      pulse(16'h0008, 80, 80);
      expCnt[3] = 16'h0000;
      readChk(3);
      chk("saved count", 16'h0000, saveCount[3]);
      chk("save strobes", 16'h0002, 16'(nSaves - saves0));
      $display("done wrap");
   endtask
   task automatic t_reject();
      pulse(16'h0002, 20, 100);
      readChk(1);
      pulse(16'h0002, 60, 10);
      pulse(16'h0002, 60, 200);
      expCnt[1]++;
      readChk(1);
      $display("done reject");
   endtask
   task automatic t_debounce();
      debEn = 16'h0020;
      pulse(16'h0020, 200, 800);
      readChk(5);
      pulse(16'h0020, 800, 800);
      expCnt[5]++;
      readChk(5);
      $display("done debounce");
   endtask
   task automatic t_level();
      @(negedge clk);
      din[7] = 1'b1;
      repeat (100) @(negedge clk);
      chk("led 7", 16'h0080, inputLed);
      expCnt[7]++;
      readChk(7);
      chk("level 7", 16'h0001, {15'h0000, rsp.level});
      din[7] = 1'b0;
      repeat (100) @(negedge clk);
      chk("led off", 16'h0000, inputLed);
      $display("done level");
   endtask
   task automatic t_serial();
      prevAct = actLed;
      master.sendByte();
      chk("activity", {15'h0000, ~prevAct}, {15'h0000, actLed});
      master.breakLink();
      chk("fault set", 16'h0001, {15'h0000, faultLed});
      master.sendByte();
      chk("fault clear", 16'h0000, {15'h0000, faultLed});
      repeat (260) @(negedge clk);
      chk("fault idle", 16'h0001, {15'h0000, faultLed});
      $display("done serial");
   endtask
   task automatic t_protect();
      int saves0;
      doReset(1'b1);
      saves0 = nSaves;
      foreach (expCnt[i]) expCnt[i] = 16'h0000;
      readChk(3);
      pulse(16'h0008, 80, 80);
      expCnt[3] = 16'h0001;
      readChk(3);
      chk("saves", 16'h0000, 16'(nSaves - saves0));
      $display("done protect");
   endtask
   task automatic final_report();
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ==========================================
   // Watchdog: a hung scenario counts as a mismatch
   initial begin
      repeat (50000) @(posedge clk);
      failures++;
      $display("[ERR] run length expected below 50000 cycles seen 50000");
      final_report();
   end
   // Start-up with restored counts and no jumper, reset held 8 cycles
   initial begin
      sysRst       = 1'b1;
      jumper       = 1'b0;
      restoreValid = 1'b1;
      din          = '0;
      debEn        = '0;
      failures     = 0;
      n_compared   = 0;
      for (int i = 0; i < 16; i++) restoreCount[i] = 16'(i);
      restoreCount[3] = 16'hFFFE; // Two pulses from wrapping
      for (int i = 0; i < 16; i++) expCnt[i] = restoreCount[i];
      repeat (8) @(negedge clk);
      sysRst = 1'b0;
      repeat (2) @(negedge clk);
      t_channels();
      t_wrap();
      t_reject();
      t_debounce();
      t_level();
      t_serial();
      t_protect();
      final_report();
   end
endmodule
`default_nettype wire
